/* core/sar_dev_end.sv */
// converter end: conversion sequencing, serial result port, power control
//
// Operation
// - convert strobe rise starts conversion, latches mode
// - daisy input low at rise: chain mode
// - daisy input high at rise: select mode
// - select mode drives output when either low
// - host reads chain data only strobe high
// - chain mode takes upstream data on daisy
// - daisy bit reaches output after sixteen clocks
// - either input low at completion: busy indication
// - fast select: 2.5 MSPS, stays powered
// - slow select: 2.0 MSPS, powers down between
// - reference powerdown low enables internal reference
// - powerdown high, bandgap node low: both off
// - result shifted out by shift clock
// - output changes follow the shift clock
// - result belongs to same conversion, no latency
// - sixteen binary weighted decisions, two arrays
// - msb first decisions, then back to acquisition
// - internal clock times conversion, not shift clock
// - host discards first fast mode result
// - straight binary, saturating at both ends
`timescale 1ns/10ps
module sar_dev_end #(
	parameter int DATA_W = sar_pkg::RES_BITS
) (
	// serial link
	sar_link_if.dev                   link,
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// held analog difference, in code steps
	input  wire logic signed [DATA_W+1:0] analogIn,
	// mode and reference straps
	input  wire logic                 turbo,
	input  wire logic                 referencePowerdownIn,
	input  wire logic                 bandgapReferenceNode,
	// status
	output logic [DATA_W-1:0]         resultCode,
	output logic                      convDone,
	output logic                      convPowered,
	output logic                      refInternalOn,
	output logic                      refBufferOn,
	output logic                      bandgapOn
);

	localparam int IDX_W = $clog2(DATA_W);

	// ==========================================================
	// state
	typedef struct packed {
		logic [sar_pkg::PIN_CNT-1:0] pinMeta;
		logic [sar_pkg::PIN_CNT-1:0] pinSync;
		logic                        sckPrev;
		logic                        cnvPrev;
		sar_pkg::sar_dev_state_t     state;
		logic                        chainMode;
		logic                        busyBit;
		logic [DATA_W-1:0]           shiftReg;
		logic [DATA_W-1:0]           sample;
		logic [DATA_W-1:0]           code;
		logic [DATA_W-1:0]           result;
		logic [IDX_W-1:0]            bitIdx;
		logic [5:0]                  stepCnt;
		logic [5:0]                  cycLeft;
		logic                        done;
		logic                        powered;
		logic                        refInt;
		logic                        refBuf;
		logic                        bandgap;
		logic                        serial_result_out;
		logic                        sdoEn;
	} sar_dev_reg_t;

	sar_dev_reg_t r;
	sar_dev_reg_t next_r;

	logic              convert_strobe;
	logic              mode_select_daisy_in;
	logic              sck;
	logic              turboS;
	logic              pdS;
	logic              bgS;
	logic              cnvRise;
	logic              sckFall;
	logic              selected;
	logic              shiftOk;
	logic [5:0]        minCyc;
	logic [DATA_W-1:0] trial;

	// ==========================================================
	// pin views, second synchroniser stage only
	assign convert_strobe     = r.pinSync[sar_pkg::PIN_CNV];
	assign mode_select_daisy_in     = r.pinSync[sar_pkg::PIN_SDI];
	assign sck     = r.pinSync[sar_pkg::PIN_SCK];
	assign turboS  = r.pinSync[sar_pkg::PIN_TRB];
	assign pdS     = r.pinSync[sar_pkg::PIN_PD];
	assign bgS     = r.pinSync[sar_pkg::PIN_BG];
	assign cnvRise = convert_strobe & ~r.cnvPrev;
	assign sckFall = r.sckPrev & ~sck;

	// out-of-range input clamps to the end codes
	function automatic logic [DATA_W-1:0] clampCode(
		input logic signed [DATA_W+1:0] v
	);
		logic [DATA_W-1:0] c;
		c = v[DATA_W-1:0];
		if (v[DATA_W+1]) begin
			c = '0;
		end else if (v[DATA_W]) begin
			c = '1;
		end
		return c;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		next_r = r;
		next_r.pinMeta = {bandgapReferenceNode, referencePowerdownIn, turbo,
			link.shiftClock, link.modeSelectDaisyIn, link.convertStrobe};
		next_r.pinSync = r.pinMeta;
		next_r.sckPrev = sck;
		next_r.cnvPrev = convert_strobe;
		next_r.done    = 1'b0;

		// least spacing between accepted conversions
		minCyc = turboS ? sar_pkg::CYC_TURBO_CYC : sar_pkg::CYC_NORMAL_CYC;
		if (r.cycLeft != 6'h00) begin
			next_r.cycLeft = r.cycLeft - 6'h01;
		end

		// positive array takes the trial code, negative its complement;
		// the comparator verdict reduces to this magnitude test
		trial = r.code | (DATA_W'(1) << r.bitIdx);

		case (r.state)
			sar_pkg::DEV_IDLE: begin
				next_r.powered = turboS;
				// too-early strobes are ignored, capping throughput
				if (cnvRise && r.cycLeft == 6'h00) begin
					next_r.chainMode = ~mode_select_daisy_in;
					next_r.sample    = clampCode(analogIn);
					next_r.code      = '0;
					next_r.bitIdx    = IDX_W'(DATA_W - 1);
					next_r.stepCnt   = 6'h00;
					next_r.cycLeft   = minCyc - 6'h01;
					next_r.powered   = 1'b1;
					next_r.state     = turboS ? sar_pkg::DEV_SAR
						: sar_pkg::DEV_WAKE;
				end
			end
			sar_pkg::DEV_WAKE: begin
				// slow mode pays a wake-up before the first decision
				next_r.stepCnt = r.stepCnt + 6'h01;
				if (r.stepCnt == sar_pkg::WAKE_CYC - 6'h01) begin
					next_r.stepCnt = 6'h00;
					next_r.state   = sar_pkg::DEV_SAR;
				end
			end
			sar_pkg::DEV_SAR: begin
				next_r.stepCnt = r.stepCnt + 6'h01;
				if (r.stepCnt == sar_pkg::SAR_STEP_CYC - 6'h01) begin
					next_r.stepCnt = 6'h00;
					if (trial <= r.sample) begin
						next_r.code = trial;
					end
					next_r.bitIdx = r.bitIdx - IDX_W'(1);
					if (r.bitIdx == '0) begin
						// result of this very sample goes out now
						next_r.result   = next_r.code;
						next_r.shiftReg = next_r.code;
						next_r.busyBit  = ~convert_strobe | ~mode_select_daisy_in;
						next_r.done     = 1'b1;
						next_r.powered  = turboS;
						next_r.state    = sar_pkg::DEV_IDLE;
					end
				end
			end
			default: begin
				next_r.state = sar_pkg::DEV_IDLE;
			end
		endcase

		// ======================================================
		// serial port
		selected = ~convert_strobe | ~mode_select_daisy_in;
		shiftOk  = r.chainMode ? convert_strobe : selected;
		if (r.state == sar_pkg::DEV_IDLE && sckFall && shiftOk) begin
			if (r.busyBit) begin
				next_r.busyBit = 1'b0;
			end else begin
				next_r.shiftReg = {r.shiftReg[DATA_W-2:0], mode_select_daisy_in};
			end
		end

		next_r.sdoEn = r.chainMode ? 1'b1 : selected;
		if (next_r.state != sar_pkg::DEV_IDLE) begin
			next_r.serial_result_out = 1'b0;
		end else if (next_r.busyBit) begin
			next_r.serial_result_out = 1'b1;
		end else begin
			next_r.serial_result_out = next_r.shiftReg[DATA_W-1];
		end

		// ======================================================
		// reference power control, straps are static
		next_r.refInt  = ~pdS;
		next_r.refBuf  = ~(pdS & ~bgS);
		next_r.bandgap = ~(pdS & ~bgS);
	end

	// ==========================================================
	// registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs
	assign link.serialResultOut   = r.serial_result_out;
	assign link.serialResultOutEn = r.sdoEn;
	assign resultCode             = r.result;
	assign convDone               = r.done;
	assign convPowered            = r.powered;
	assign refInternalOn          = r.refInt;
	assign refBufferOn            = r.refBuf;
	assign bandgapOn              = r.bandgap;

endmodule

/* core/sar_host_end.sv */
// host end: axi4-lite registers driving conversions and serial reads
`timescale 1ns/10ps
module sar_host_end #(
	parameter int DATA_W   = sar_pkg::RES_BITS,
	parameter int SCK_HALF = sar_pkg::SCK_HALF_CYC
) (
	// serial link
	sar_link_if.ctl           link,
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// axi4-lite slave
	input  wire logic [3:0]   awaddr,
	input  wire logic         awvalid,
	output logic              awready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	input  wire logic         wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  wire logic         bready,
	input  wire logic [3:0]   araddr,
	input  wire logic         arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  wire logic         rready,
	// converter strap
	output logic              turboSel
);

	// ==========================================================
	// state
	typedef struct packed {
		logic                    sdoMeta;
		logic                    sdoSync;
		sar_pkg::sar_hst_state_t state;
		logic [7:0]              cnt;
		logic [4:0]              bitCnt;
		logic                    sck;
		logic                    convert_strobe;
		logic                    mode_select_daisy_in;
		logic [DATA_W-1:0]       shiftIn;
		logic [DATA_W-1:0]       dataReg;
		logic                    valid;
		logic                    chain;
		logic                    busyInd;
		logic                    turbo;
		logic                    firstPending;
		logic                    runChain;
		logic                    runBusy;
		logic                    awHeld;
		logic [3:0]              awAddr;
		logic                    wHeld;
		logic [31:0]             wData;
		logic                    wStrb0;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
	} sar_hst_reg_t;

	sar_hst_reg_t r;
	sar_hst_reg_t next_r;
	logic         startReq;
	logic [4:0]   lastBit;

	assign awready = ~r.awHeld & ~r.bvalid;
	assign wready  = ~r.wHeld & ~r.bvalid;
	assign arready = ~r.rvalid;

	// ==========================================================
	// next state
	always_comb begin
		next_r         = r;
		next_r.sdoMeta = link.serialResultLine;
		next_r.sdoSync = r.sdoMeta;
		startReq       = 1'b0;
		lastBit        = r.runBusy ? 5'(DATA_W) : 5'(DATA_W - 1);

		// bus: address and data may arrive in either order
		if (awvalid && awready) begin
			next_r.awHeld = 1'b1;
			next_r.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			next_r.wHeld  = 1'b1;
			next_r.wData  = wdata;
			next_r.wStrb0 = wstrb[0];
		end
		if (r.awHeld && r.wHeld) begin
			next_r.awHeld = 1'b0;
			next_r.wHeld  = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = sar_pkg::RESP_OKAY;
			if (r.awAddr == sar_pkg::REG_CTRL) begin
				if (r.wStrb0) begin
					next_r.chain   = r.wData[sar_pkg::CTRL_CHAIN];
					next_r.busyInd = r.wData[sar_pkg::CTRL_BUSY];
					next_r.turbo   = r.wData[sar_pkg::CTRL_TURBO];
					if (r.wData[sar_pkg::CTRL_TURBO] && !r.turbo) begin
						next_r.firstPending = 1'b1;
					end
					startReq = r.wData[sar_pkg::CTRL_START];
				end
			end else if (r.awAddr == sar_pkg::REG_STATUS
					|| r.awAddr == sar_pkg::REG_DATA) begin
				next_r.bresp = sar_pkg::RESP_OKAY;
			end else begin
				next_r.bresp = sar_pkg::RESP_SLVERR;
			end
		end
		if (r.bvalid && bready) begin
			next_r.bvalid = 1'b0;
		end

		if (r.rvalid && rready) begin
			next_r.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_r.rvalid = 1'b1;
			next_r.rresp  = sar_pkg::RESP_OKAY;
			next_r.rdata  = 32'h0000_0000;
			if (araddr == sar_pkg::REG_CTRL) begin
				next_r.rdata[3:1] = {r.turbo, r.busyInd, r.chain};
			end else if (araddr == sar_pkg::REG_STATUS) begin
				next_r.rdata[sar_pkg::STAT_ACTIVE] = r.state != sar_pkg::HST_IDLE;
				next_r.rdata[sar_pkg::STAT_VALID]  = r.valid;
			end else if (araddr == sar_pkg::REG_DATA) begin
				next_r.rdata[DATA_W-1:0] = r.dataReg;
				next_r.valid             = 1'b0;
			end else begin
				next_r.rresp = sar_pkg::RESP_SLVERR;
			end
		end

		// ======================================================
		// conversion and read sequence
		case (r.state)
			sar_pkg::HST_IDLE: begin
				if (startReq) begin
					next_r.runChain = next_r.chain;
					next_r.runBusy  = next_r.chain | next_r.busyInd;
					next_r.mode_select_daisy_in      = ~next_r.chain;
					next_r.cnt      = 8'h00;
					next_r.state    = sar_pkg::HST_SETUP;
				end
			end
			sar_pkg::HST_SETUP: begin
				next_r.cnt = r.cnt + 8'h01;
				if (r.cnt == sar_pkg::SETUP_CYC - 8'h01) begin
					next_r.convert_strobe   = 1'b1;
					next_r.cnt   = 8'h00;
					next_r.state = sar_pkg::HST_WAIT;
				end
			end
			sar_pkg::HST_WAIT: begin
				if (r.cnt != 8'hFF) begin
					next_r.cnt = r.cnt + 8'h01;
				end
				if (r.runBusy) begin
					if (!r.runChain && r.cnt == sar_pkg::SDI_DROP_CYC) begin
						next_r.mode_select_daisy_in = 1'b0;
					end
					if (r.cnt >= sar_pkg::BUSY_MIN_CYC && r.sdoSync) begin
						next_r.cnt    = 8'h00;
						next_r.bitCnt = 5'h00;
						next_r.state  = sar_pkg::HST_SHIFT;
					end
				end else if (r.cnt == sar_pkg::CONV_WAIT_CYC - 8'h01) begin
					next_r.convert_strobe    = 1'b0;
					next_r.cnt    = 8'h00;
					next_r.bitCnt = 5'h00;
					next_r.state  = sar_pkg::HST_SHIFT;
				end
			end
			sar_pkg::HST_SHIFT: begin
				next_r.cnt = r.cnt + 8'h01;
				if (r.cnt == 8'(SCK_HALF - 1)) begin
					next_r.cnt = 8'h00;
					if (!r.sck) begin
						next_r.sck = 1'b1;
					end else begin
						// sample late in the high phase, then fall
						next_r.shiftIn = {r.shiftIn[DATA_W-2:0], r.sdoSync};
						next_r.sck     = 1'b0;
						next_r.bitCnt  = r.bitCnt + 5'h01;
						if (r.bitCnt == lastBit) begin
							next_r.state = sar_pkg::HST_DONE;
						end
					end
				end
			end
			sar_pkg::HST_DONE: begin
				next_r.convert_strobe     = 1'b0;
				next_r.mode_select_daisy_in     = ~r.runChain;
				next_r.dataReg = r.shiftIn;
				if (r.turbo && r.firstPending) begin
					next_r.firstPending = 1'b0;
				end else begin
					next_r.valid = 1'b1;
				end
				next_r.state = sar_pkg::HST_IDLE;
			end
			default: begin
				next_r.state = sar_pkg::HST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r              <= '0;
			r.mode_select_daisy_in          <= 1'b1;
			r.firstPending <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs
	assign link.convertStrobe     = r.convert_strobe;
	assign link.modeSelectDaisyIn = r.mode_select_daisy_in;
	assign link.shiftClock        = r.sck;
	assign bresp                  = r.bresp;
	assign bvalid                 = r.bvalid;
	assign rdata                  = r.rdata;
	assign rresp                  = r.rresp;
	assign rvalid                 = r.rvalid;
	assign turboSel               = r.turbo;

endmodule

/* core/sar_link_if.sv */
// serial link between the converter and its host
`timescale 1ns/10ps
interface sar_link_if;
	logic convertStrobe;
	logic modeSelectDaisyIn;
	logic shiftClock;
	logic serialResultOut;
	logic serialResultOutEn;
	wire  serialResultLine;

	// released line reads low, as if pulled down, so the host never
	// mistakes a released line for the high busy-done level
	assign serialResultLine = serialResultOutEn ? serialResultOut : 1'b0;

	modport dev (
		input  convertStrobe,
		input  modeSelectDaisyIn,
		input  shiftClock,
		output serialResultOut,
		output serialResultOutEn
	);

	modport ctl (
		output convertStrobe,
		output modeSelectDaisyIn,
		output shiftClock,
		input  serialResultLine
	);
endinterface

/* core/sar_pkg.sv */
// shared constants and types for the converter control and its readout host
package sar_pkg;

	// ==========================================================
	// clock and resolution
	localparam int CLK_MHZ  = 100;
	localparam int RES_BITS = 16;

	// ==========================================================
	// conversion timing, nanoseconds as printed
	localparam int CONV_TURBO_NS  = 320;
	localparam int CONV_NORMAL_NS = 420;
	localparam int CYC_TURBO_NS   = 400;
	localparam int CYC_NORMAL_NS  = 500;

	// longest times round down, least times round up
	localparam logic [5:0] CONV_TURBO_CYC  = 6'(CONV_TURBO_NS * CLK_MHZ / 1000);
	localparam logic [5:0] CONV_NORMAL_CYC = 6'(CONV_NORMAL_NS * CLK_MHZ / 1000);
	localparam logic [5:0] CYC_TURBO_CYC   =
		6'((CYC_TURBO_NS * CLK_MHZ + 999) / 1000);
	localparam logic [5:0] CYC_NORMAL_CYC  =
		6'((CYC_NORMAL_NS * CLK_MHZ + 999) / 1000);
	localparam logic [5:0] SAR_STEP_CYC    = 6'(CONV_TURBO_CYC / RES_BITS);
	localparam logic [5:0] WAKE_CYC        = CONV_NORMAL_CYC - CONV_TURBO_CYC;

	// ==========================================================
	// host sequencing counts
	localparam int         SCK_HALF_CYC    = 6;
	localparam logic [7:0] SETUP_CYC       = 8'h02;
	localparam logic [7:0] SDI_DROP_CYC    = 8'h03;
	localparam logic [7:0] BUSY_MIN_CYC    = 8'h08;
	localparam logic [7:0] SYNC_MARGIN_CYC = 8'h08;
	localparam logic [7:0] CONV_WAIT_CYC   =
		8'(CONV_NORMAL_CYC) + SYNC_MARGIN_CYC;

	// ==========================================================
	// device pin synchroniser lanes
	localparam int PIN_CNV  = 0;
	localparam int PIN_SDI  = 1;
	localparam int PIN_SCK  = 2;
	localparam int PIN_TRB  = 3;
	localparam int PIN_PD   = 4;
	localparam int PIN_BG   = 5;
	localparam int PIN_CNT  = 6;

	// ==========================================================
	// host register map
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	localparam logic [3:0] REG_DATA    = 4'h8;
	localparam int         CTRL_START  = 0;
	localparam int         CTRL_CHAIN  = 1;
	localparam int         CTRL_BUSY   = 2;
	localparam int         CTRL_TURBO  = 3;
	localparam int         STAT_ACTIVE = 0;
	localparam int         STAT_VALID  = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// state encodings
	typedef enum logic [1:0] {
		DEV_IDLE = 2'h0,
		DEV_WAKE = 2'h1,
		DEV_SAR  = 2'h3
	} sar_dev_state_t;

	typedef enum logic [2:0] {
		HST_IDLE  = 3'h0,
		HST_SETUP = 3'h1,
		HST_WAIT  = 3'h3,
		HST_SHIFT = 3'h2,
		HST_DONE  = 3'h6
	} sar_hst_state_t;

endpackage

/* test/sar_link_asserts.sv */
// link assertions for the converter and its host
`timescale 1ns/10ps
module sar_link_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// link
	input wire logic convertStrobe,
	input wire logic modeSelectDaisyIn,
	input wire logic shiftClock,
	input wire logic serialResultOut,
	input wire logic serialResultOutEn
);
	typedef struct packed {
		logic       chain;
		logic       seen;
		logic       cnvQ;
		logic [3:0] age;
		logic [2:0] hi;
		logic [2:0] lo;
		logic [2:0] sckHi;
	} sar_chk_t;

	sar_chk_t s;
	sar_chk_t next_s;

	// =====================================================
	// helper counters
	// saturating, so that long idle spans stay true
	function automatic logic [2:0] sat(input logic on, input logic [2:0] c);
		return on ? c + 3'(c != 3'h7) : 3'h0;
	endfunction

	always_comb begin
		next_s = s;
		next_s.cnvQ = convertStrobe;
		next_s.hi = sat(convertStrobe && modeSelectDaisyIn, s.hi);
		next_s.lo = sat(!convertStrobe, s.lo);
		next_s.sckHi = sat(shiftClock, s.sckHi);
		next_s.age = s.age + 4'(s.age != 4'hF);
		if (convertStrobe && !s.cnvQ) begin
			next_s.chain = !modeSelectDaisyIn;
			next_s.seen = 1'b1;
			next_s.age = 4'h0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	// =====================================================
	// properties
	default clocking cbk @(posedge mclk); endclocking
	default disable iff (rst);

	AST_SEL_OFF: assert property (
		s.seen && !s.chain && s.age > 4'h7 && s.hi > 3'h5 |->
		!serialResultOutEn) else $error("output driven while deselected");
	AST_LOW_EN: assert property (
		s.seen && s.lo > 3'h5 |-> serialResultOutEn)
		else $error("output released while strobe low");
	AST_CHAIN_EN: assert property (
		s.chain && s.age > 4'h7 |-> serialResultOutEn)
		else $error("output released in chain mode");
	AST_BUSY_LOW: assert property (
		$rose(convertStrobe) |-> ##6 (!serialResultOut) [*8])
		else $error("output not low while converting");
	AST_SCK_STABLE: assert property (
		s.sckHi > 3'h3 |-> $stable(serialResultOut))
		else $error("output moved while shift clock high");
	AST_SDI_HOLD: assert property (
		$rose(convertStrobe) |->
		$stable(modeSelectDaisyIn) ##1 $stable(modeSelectDaisyIn))
		else $error("daisy input moved around strobe rise");
	AST_CHAIN_READ: assert property (
		s.chain && $changed(shiftClock) |->
		convertStrobe || $past(convertStrobe))
		else $error("chain read with strobe low");
	AST_SCK_QUIET: assert property (
		$rose(convertStrobe) |-> (!shiftClock) [*8])
		else $error("shift clock runs at conversion start");

	cover property ($rose(convertStrobe) && !modeSelectDaisyIn);
	cover property ($rose(convertStrobe) && modeSelectDaisyIn);
	cover property (s.chain && $fell(shiftClock));
endmodule

/* test/tb_sar_adc_serial_readout.sv */
// self-checking bench for converter and host joined by the link
`timescale 1ns/10ps
module tb_sar_adc_serial_readout;
	// =====================================================
	// bench signals
	logic               mclk = 1'b0;
	logic               rst = 1'b1;
	logic [3:0]         awaddr = 4'h0;
	logic               awvalid = 1'b0;
	logic [31:0]        wdata = 32'h0;
	logic [3:0]         wstrb = 4'hF;
	logic               wvalid = 1'b0;
	logic               bready = 1'b0;
	logic [3:0]         araddr = 4'h0;
	logic               arvalid = 1'b0;
	logic               rready = 1'b0;
	logic signed [17:0] analogIn = 18'sh0;
	logic               referencePowerdownIn = 1'b0;
	logic               bandgapReferenceNode = 1'b0;
	logic               awready, wready, bvalid, arready, rvalid, turboSel;
	logic               convPowered, refInternalOn, refBufferOn, bandgapOn;
	logic               convDone;
	logic [1:0]         bresp, rresp, rsp;
	logic [31:0]        rdata, rd;
	logic [15:0]        resultCode;
	logic               lastTurbo = 1'b0;
	int                 err_total = 0;
	int                 checked = 0;
	int                 doneCnt = 0;
	int                 expDone = 0;
	// straight binary rows, both clamp ends included
	logic [17:0] rowAin [8] = '{18'h01234, 18'h0FFFF, 18'h10000, 18'h3FFFB,
		18'h08000, 18'h00001, 18'h07FFF, 18'h00000};
	logic [3:0]  rowMode [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'h8, 4'hC, 4'hA, 4'h0};
	logic [15:0] rowExp [8] = '{16'h1234, 16'hFFFF, 16'hFFFF, 16'h0000,
		16'h8000, 16'h0001, 16'h7FFF, 16'h0000};

	// =====================================================
	// design and checker
	sar_link_if sar_link_if_i ();
	sar_dev_end sar_dev_end_i (
		.link(sar_link_if_i.dev), .mclk(mclk), .rst(rst),
		.analogIn(analogIn), .turbo(turboSel),
		.referencePowerdownIn(referencePowerdownIn),
		.bandgapReferenceNode(bandgapReferenceNode),
		.resultCode(resultCode), .convDone(convDone),
		.convPowered(convPowered),
		.refInternalOn(refInternalOn), .refBufferOn(refBufferOn),
		.bandgapOn(bandgapOn)
	);
	sar_host_end sar_host_end_i (
		.link(sar_link_if_i.ctl), .mclk(mclk), .rst(rst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.turboSel(turboSel)
	);
	sar_link_asserts sar_link_asserts_i (
		.mclk(mclk), .rst(rst),
		.convertStrobe(sar_link_if_i.convertStrobe),
		.modeSelectDaisyIn(sar_link_if_i.modeSelectDaisyIn),
		.shiftClock(sar_link_if_i.shiftClock),
		.serialResultOut(sar_link_if_i.serialResultOut),
		.serialResultOutEn(sar_link_if_i.serialResultOutEn)
	);

	initial begin
		forever #5 mclk = ~mclk;
	end

	// completion pulses, one per accepted conversion
	always @(posedge mclk) begin
		if (convDone === 1'b1)
			doneCnt <= doneCnt + 1;
	end

	// =====================================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic axiWr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end while (!(bvalid === 1'b1 && !aw && !w));
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axiRd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar;
		ar = 1'b1;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (ar && arready) begin
				ar = 1'b0;
				arvalid <= 1'b0;
			end
		end while (!(rvalid === 1'b1 && !ar));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// one conversion and read; the input moves once it has been sampled
	task automatic runOne(input logic [17:0] ain, input logic [3:0] md,
		input logic [15:0] ex, input logic keep);
		analogIn <= ain;
		expDone++;
		axiWr(sar_pkg::REG_CTRL, {28'h0, md | 4'h1}, rsp);
		while (sar_link_if_i.convertStrobe !== 1'b1) begin
			@(posedge mclk);
		end
		repeat (8) @(posedge mclk);
		analogIn <= 18'sh2AAAA;
		do begin
			axiRd(sar_pkg::REG_STATUS, rd, rsp);
		end while (rd[sar_pkg::STAT_ACTIVE] !== 1'b0);
		check("valid", 32'(rd[sar_pkg::STAT_VALID]), 32'(keep));
		if (keep) begin
			axiRd(sar_pkg::REG_DATA, rd, rsp);
			check("data", rd, {16'h0, ex});
			check("code", 32'(resultCode), 32'(ex));
		end
	endtask

	// =====================================================
	// main sequence
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			axiWr(sar_pkg::REG_CTRL, {28'h0, rowMode[i]}, rsp);
			if (rowMode[i][3] && !lastTurbo)
				runOne(rowAin[i], rowMode[i], 16'h0, 1'b0);
			lastTurbo = rowMode[i][3];
			runOne(rowAin[i], rowMode[i], rowExp[i], 1'b1);
			check("powered", 32'(convPowered), 32'(rowMode[i][3]));
		end
		check("done", 32'(doneCnt), 32'(expDone));
		// reference straps, all four combinations
		for (int k = 0; k < 4; k++) begin
			referencePowerdownIn <= k[0];
			bandgapReferenceNode <= k[1];
			repeat (5) @(posedge mclk);
			check("ref", 32'(refInternalOn), 32'(!k[0]));
			check("buf", 32'({refBufferOn, bandgapOn}),
				32'({2{!(k[0] && !k[1])}}));
		end
		axiWr(4'hC, 32'h0, rsp);
		check("wresp", 32'(rsp), 32'(sar_pkg::RESP_SLVERR));
		axiRd(4'hC, rd, rsp);
		check("rresp", 32'(rsp), 32'(sar_pkg::RESP_SLVERR));
		check("rdata", rd, 32'h0);
		axiWr(sar_pkg::REG_CTRL, 32'hE, rsp);
		axiRd(sar_pkg::REG_CTRL, rd, rsp);
		check("ctrl", rd, 32'hE);
		// a write without its low byte lane leaves control alone
		wstrb <= 4'h0;
		axiWr(sar_pkg::REG_CTRL, 32'h0, rsp);
		wstrb <= 4'hF;
		axiRd(sar_pkg::REG_CTRL, rd, rsp);
		check("strobe", rd, 32'hE);
		// reset in the middle of a conversion
		axiWr(sar_pkg::REG_CTRL, 32'h1, rsp);
		repeat (10) @(posedge mclk);
		rst <= 1'b1;
		repeat (8) @(negedge mclk);
		check("reset", 32'({sar_link_if_i.convertStrobe,
			sar_link_if_i.serialResultOutEn, bvalid, resultCode}), 32'h0);
		@(posedge mclk);
		rst <= 1'b0;
		axiRd(sar_pkg::REG_STATUS, rd, rsp);
		check("status", rd, 32'h0);
		give_verdict();
	end

	// hang guard, far beyond the expected run
	initial begin
		#200000;
		err_total++;
		give_verdict();
	end
endmodule
